//--- rtl/dst_regs.svh
`ifndef DST_REGS_SVH
`define DST_REGS_SVH

// register byte offsets
`define DST_CTRL_OFS 12'h000
`define DST_PLL_OFS 12'h004
`define DST_DRIVE_OFS 12'h008
`define DST_STATUS_OFS 12'h00C

// ctrl fields
`define DST_CTRL_DIS 0
`define DST_CTRL_RATE_LO 1
`define DST_CTRL_RATE_HI 2
// pll fields
`define DST_PLL_OFF 3
`define DST_PLL_UNUSED 2
`define DST_PLL_STG_HI 1
`define DST_PLL_STG_LO 0
`define DST_PLL_CP_LO 4
`define DST_PLL_CP_HI 7
// drive fields
`define DST_DRV_MAIN_LO 0
`define DST_DRV_MAIN_HI 3
`define DST_DRV_EMPH_LO 4
`define DST_DRV_EMPH_HI 7

// reset values
`define DST_CTRL_RST 3'h0
`define DST_PLL_RST 8'h50
`define DST_DRIVE_RST 8'h00

// serializer geometry
`define DST_WORD_W 30
`define DST_HALF_W 15
`define DST_DIV_A 2'h2
`define DST_DIV_B 3'h4

// timing
`define DST_CLK_PERIOD_NS 10
`define DST_LOCK_TIME_NS 9000
`define DST_LOCK_CYC \
    ((`DST_LOCK_TIME_NS + `DST_CLK_PERIOD_NS - 1) / `DST_CLK_PERIOD_NS)

`endif

//--- rtl/dst_pkg.sv
package dst_pkg;

    typedef enum logic [1:0] {
        DST_RATE_1G2 = 2'h0,
        DST_RATE_600 = 2'h1,
        DST_RATE_400 = 2'h2
    } dst_rate_e;

    typedef enum logic [2:0] {
        DST_PLL_IDLE = 3'h1,
        DST_PLL_ACQ = 3'h2,
        DST_PLL_LOCK = 3'h4
    } dst_pll_e;

    typedef struct packed {
        logic [3:0] main_code;
        logic [3:0] emph_code;
    } dst_drive_s;

    typedef struct packed {
        logic power_down;
        logic [2:0] vco_stages;
        logic [3:0] cp_code;
    } dst_pll_s;

    typedef logic [14:0] dst_half_t;

endpackage

//--- rtl/dst_top.sv
`timescale 1ns/1ps
`include "dst_regs.svh"

// What this block does
// - load 30-bit word when load enable
// - even bits one register, odd other
// - alternate-step shift on rising edges, merged into one stream
// - load strobe aligned to divider chain
// - rate selectable 1.2G, 600M, 400M
// - emphasis one bit, only on change
// - one-bit delayed copy drives emphasis
// - slow rate emphasis spans one third
// - shift storage triplicated with majority vote
// - separate 4-bit main, emphasis current codes
// - pll bit3 off, bit2 ignored
// - low pll bits pick vco stages
// - 4-bit charge pump code, nominal 10uA
// - divide by 3 then 5; 200M available at 1.2G and 400M rates
// - disable shuts transmitter down
module dst_top
    import dst_pkg::*;
(
    input wire logic pclk, // bus and bit clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped
    input wire logic load_en, // core word valid
    input wire logic [29:0] data_in, // encoded word
    output logic word_taken, // word accepted this cycle
    output logic serial_out, // line, true side
    output logic serial_out_n, // line, complement side
    output logic emph_out, // delayed stream to emphasis
    output logic emph_active, // emphasis driver on
    output logic clk200_tick, // phase marker, 200 mhz at 1.2g and 400m, 100 mhz at 600m
    output logic pll_lock, // pll lock indicator
    output dst_drive_s drive, // driver current codes
    output dst_pll_s pll_ctl // pll analog controls
);

    // ==========================================================
    // helpers
    function automatic logic [2:0] dst_decode(input logic [11:0] a);
        logic [2:0] idx;
        idx = 3'h4;
        if (a == `DST_CTRL_OFS) begin
            idx = 3'h0;
        end else if (a == `DST_PLL_OFS) begin
            idx = 3'h1;
        end else if (a == `DST_DRIVE_OFS) begin
            idx = 3'h2;
        end else if (a == `DST_STATUS_OFS) begin
            idx = 3'h3;
        end
        return idx;
    endfunction

    function automatic dst_half_t dst_vote(input dst_half_t a,
                                           input dst_half_t b,
                                           input dst_half_t c);
        return (a & b) | (a & c) | (b & c);
    endfunction

    // ==========================================================
    // register file
    logic [2:0] ctrl;
    logic [7:0] pll_reg;
    logic [7:0] drive_reg;
    logic [2:0] next_ctrl;
    logic [7:0] next_pll_reg;
    logic [7:0] next_drive_reg;
    logic [31:0] next_prdata;
    logic [2:0] wr_idx;
    logic [2:0] rd_idx;
    logic [31:0] status_word;
    logic wr_go;
    dst_pll_e pll_st;

    assign wr_idx = dst_decode(paddr);
    assign rd_idx = wr_idx;
    assign wr_go = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & (wr_idx == 3'h4);

    always_comb begin
        next_ctrl = ctrl;
        next_pll_reg = pll_reg;
        next_drive_reg = drive_reg;
        next_prdata = prdata;
        if (wr_go && wr_idx == 3'h0) begin
            next_ctrl = pwdata[`DST_CTRL_RATE_HI:`DST_CTRL_DIS];
        end
        if (wr_go && wr_idx == 3'h1) begin
            next_pll_reg = pwdata[`DST_PLL_CP_HI:`DST_PLL_STG_LO];
        end
        if (wr_go && wr_idx == 3'h2) begin
            next_drive_reg = pwdata[`DST_DRV_EMPH_HI:`DST_DRV_MAIN_LO];
        end
        // read data captured in setup, stable through access
        if (psel && !penable && !pwrite) begin
            if (rd_idx == 3'h0) begin
                next_prdata = {29'h0, ctrl};
            end else if (rd_idx == 3'h1) begin
                next_prdata = {24'h0, pll_reg};
            end else if (rd_idx == 3'h2) begin
                next_prdata = {24'h0, drive_reg};
            end else if (rd_idx == 3'h3) begin
                next_prdata = status_word;
            end else begin
                next_prdata = 32'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `DST_CTRL_RST;
            pll_reg <= `DST_PLL_RST;
            drive_reg <= `DST_DRIVE_RST;
            prdata <= 32'h0;
        end else begin
            ctrl <= next_ctrl;
            pll_reg <= next_pll_reg;
            drive_reg <= next_drive_reg;
            prdata <= next_prdata;
        end
    end

    // ==========================================================
    // analog controls
    logic disabled;
    dst_rate_e rate;
    logic [2:0] stages;

    assign disabled = ctrl[`DST_CTRL_DIS];
    assign rate = dst_rate_e'(ctrl[`DST_CTRL_RATE_HI:`DST_CTRL_RATE_LO]);

    always_comb begin
        // bit 2 of the pll field is never read
        case (pll_reg[`DST_PLL_STG_HI:`DST_PLL_STG_LO])
            2'h0: stages = 3'h3;
            2'h1: stages = 3'h4;
            2'h3: stages = 3'h5;
            default: stages = 3'h4;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive <= '0;
            pll_ctl <= '{1'b1, 3'h3, 4'h5};
        end else begin
            drive.main_code <= drive_reg[`DST_DRV_MAIN_HI:`DST_DRV_MAIN_LO];
            drive.emph_code <= drive_reg[`DST_DRV_EMPH_HI:`DST_DRV_EMPH_LO];
            pll_ctl.power_down <= pll_reg[`DST_PLL_OFF] | disabled;
            pll_ctl.vco_stages <= stages;
            pll_ctl.cp_code <= pll_reg[`DST_PLL_CP_HI:`DST_PLL_CP_LO];
        end
    end

    // ==========================================================
    // pll lock sequencer
    localparam int LOCK_CYC = `DST_LOCK_CYC;
    dst_pll_e next_pll_st;
    logic [11:0] lock_cnt;
    logic [11:0] next_lock_cnt;
    logic pll_off;

    assign pll_off = pll_reg[`DST_PLL_OFF] | disabled;

    always_comb begin
        next_pll_st = pll_st;
        next_lock_cnt = lock_cnt;
        case (pll_st)
            DST_PLL_IDLE: begin
                next_lock_cnt = 12'h0;
                if (!pll_off) begin
                    next_pll_st = DST_PLL_ACQ;
                end
            end
            DST_PLL_ACQ: begin
                next_lock_cnt = lock_cnt + 12'h1;
                if (pll_off) begin
                    next_pll_st = DST_PLL_IDLE;
                end else if (lock_cnt == 12'(LOCK_CYC - 1)) begin
                    next_pll_st = DST_PLL_LOCK;
                end
            end
            DST_PLL_LOCK: begin
                if (pll_off) begin
                    next_pll_st = DST_PLL_IDLE;
                end
            end
            default: next_pll_st = DST_PLL_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_st <= DST_PLL_IDLE;
            lock_cnt <= 12'h0;
        end else begin
            pll_st <= next_pll_st;
            lock_cnt <= next_lock_cnt;
        end
    end

    assign pll_lock = (pll_st == DST_PLL_LOCK);

    // ==========================================================
    // serializer timing: half cycle, div3, div5
    logic run;
    logic step;
    logic slow;
    logic half;
    logic [1:0] div3;
    logic [2:0] div5;
    logic next_slow;
    logic next_half;
    logic [1:0] next_div3;
    logic [2:0] next_div5;
    logic frame_end;

    assign run = pll_lock & ~disabled;
    // 600 mb/s advances one line bit every two clocks
    assign step = run & ((rate != DST_RATE_600) | slow);
    assign frame_end = half & (div3 == `DST_DIV_A) & (div5 == `DST_DIV_B);
    // load only at the divider wrap keeps word and fast clock aligned
    assign word_taken = step & frame_end & load_en;

    always_comb begin
        next_slow = run & ~slow;
        next_half = half;
        next_div3 = div3;
        next_div5 = div5;
        if (!run) begin
            next_half = 1'b0;
            next_div3 = 2'h0;
            next_div5 = 3'h0;
        end else if (step) begin
            next_half = ~half;
            if (half) begin
                if (div3 == `DST_DIV_A) begin
                    next_div3 = 2'h0;
                    next_div5 = (div5 == `DST_DIV_B) ? 3'h0 : div5 + 3'h1;
                end else begin
                    next_div3 = div3 + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow <= 1'b0;
            half <= 1'b0;
            div3 <= 2'h0;
            div5 <= 3'h0;
            clk200_tick <= 1'b0;
        end else begin
            slow <= next_slow;
            half <= next_half;
            div3 <= next_div3;
            div5 <= next_div5;
            clk200_tick <= run & (div3 == 2'h0) & ~half;
        end
    end

    // ==========================================================
    // triplicated shift registers
    dst_half_t even_q [3];
    dst_half_t odd_q [3];
    dst_half_t even_v;
    dst_half_t odd_v;
    dst_half_t next_even;
    dst_half_t next_odd;
    logic next_line;

    assign even_v = dst_vote(even_q[0], even_q[1], even_q[2]);
    assign odd_v = dst_vote(odd_q[0], odd_q[1], odd_q[2]);

    always_comb begin
        next_even = even_v;
        next_odd = odd_v;
        next_line = serial_out;
        if (!run) begin
            next_even = '0;
            next_odd = '0;
            next_line = 1'b0;
        end else if (step) begin
            // word bits leave unchanged, bit 0 first
            if (!half) begin
                next_line = even_v[0];
                next_even = {1'b0, even_v[14:1]};
            end else begin
                next_line = odd_v[0];
                next_odd = {1'b0, odd_v[14:1]};
            end
            if (word_taken) begin
                for (int i = 0; i < `DST_HALF_W; i++) begin
                    next_even[i] = data_in[2 * i];
                    next_odd[i] = data_in[2 * i + 1];
                end
            end
        end
    end

    for (genvar k = 0; k < 3; k++) begin : g_tmr
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                even_q[k] <= '0;
                odd_q[k] <= '0;
            end else begin
                even_q[k] <= next_even;
                odd_q[k] <= next_odd;
            end
        end
    end

    // ==========================================================
    // line and pre-emphasis
    logic next_emph_out;
    logic next_emph_active;

    always_comb begin
        next_emph_out = emph_out;
        next_emph_active = emph_active;
        if (!run) begin
            // delayed copy keeps trailing the line while stopped
            next_emph_out = serial_out;
            next_emph_active = 1'b0;
        end else if (step) begin
            // tripled bits make the change last one of three
            next_emph_out = serial_out;
            next_emph_active = next_line ^ serial_out;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out <= 1'b0;
            serial_out_n <= 1'b1;
            emph_out <= 1'b0;
            emph_active <= 1'b0;
        end else begin
            serial_out <= next_line;
            serial_out_n <= ~next_line;
            emph_out <= next_emph_out;
            emph_active <= next_emph_active;
        end
    end

    assign status_word = {24'h0, 2'h0, run, pll_st, pll_lock, disabled};

endmodule

//--- verif/dst_checker.sv
`timescale 1ns/1ps
// ====================================================
// checker on the transmitter ports
module dst_checker
    import dst_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic [11:0] paddr, // apb address
    input wire logic pslverr, // apb error
    input wire logic word_taken, // word loaded
    input wire logic serial_out, // line true
    input wire logic serial_out_n, // line complement
    input wire logic emph_out, // delayed stream
    input wire logic emph_active, // emphasis on
    input wire logic pll_lock, // lock
    input wire dst_pll_s pll_ctl // pll controls
);
    default clocking cb @(posedge pclk); endclocking
    // ====================================================
    // clocks since last load
    logic [7:0] gap;
    logic [7:0] next_gap;
    always_comb begin
        next_gap = gap;
        if (word_taken) begin
            next_gap = 8'h00;
        end else if (gap != 8'hFF) begin
            next_gap = gap + 8'h01;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap <= 8'hFF;
        end else begin
            gap <= next_gap;
        end
    end
    // ====================================================
    // assertions
    line_pair_a: assert property (
        disable iff (!presetn) serial_out_n == !serial_out)
        else $error("line sides not complementary");
    reset_line_a: assert property (
        !presetn |-> !serial_out && serial_out_n && !emph_out)
        else $error("line not idle in reset");
    frame_gap_a: assert property (
        disable iff (!presetn) word_taken |-> gap >= 8'h1D)
        else $error("loads closer than one frame");
    load_lock_a: assert property (
        disable iff (!presetn) word_taken |-> pll_lock)
        else $error("load without lock");
    emph_delay_a: assert property (
        disable iff (!presetn)
        $changed(emph_out) |-> emph_out == $past(serial_out))
        else $error("delayed stream not previous bit");
    emph_change_a: assert property (
        disable iff (!presetn) emph_active |-> serial_out != emph_out)
        else $error("emphasis on without a bit change");
    pll_off_a: assert property (
        disable iff (!presetn) pll_ctl.power_down |=> !pll_lock)
        else $error("lock while pll off");
    bad_addr_a: assert property (
        disable iff (!presetn)
        psel && penable && paddr > 12'h00C |-> pslverr)
        else $error("unmapped access not refused");
    cover property (disable iff (!presetn) word_taken);
    cover property (disable iff (!presetn) emph_active);
    cover property (disable iff (!presetn) psel && pslverr);
endmodule

//--- verif/dst_rx.sv
`timescale 1ns/1ps
// ====================================================
// receiver model: rebuilds words from the line
module dst_rx
    import dst_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic word_taken, // frame marker
    input wire logic serial_out, // line
    input dst_rate_e rate, // line rate
    output logic [29:0] rx_word, // last word
    output logic [7:0] rx_cnt // words seen
);
    logic run;
    logic [1:0] t;
    logic [1:0] div;
    logic [4:0] idx;
    logic [28:0] sh;
    dst_rate_e last;
    assign div = (rate == DST_RATE_600) ? 2'h2 : 2'h1;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 1'b0;
            rx_cnt <= 8'h00;
            rx_word <= 30'h0;
            last <= DST_RATE_1G2;
        end else if (rate != last) begin
            run <= 1'b0;
            last <= rate;
        end else if (!run) begin
            if (word_taken) begin
                run <= 1'b1;
                t <= div;
                idx <= 5'h00;
            end
        end else if (t != 2'h0) begin
            t <= t - 2'h1;
        end else begin
            // line order is bit 0 first
            t <= div - 2'h1;
            if (idx == 5'h1D) begin
                rx_word <= {serial_out, sh};
                rx_cnt <= rx_cnt + 8'h01;
                idx <= 5'h00;
            end else begin
                sh[idx] <= serial_out;
                idx <= idx + 5'h01;
            end
        end
    end
endmodule

//--- verif/dst_top_tb.sv
`timescale 1ns/1ps
`include "dst_regs.svh"
module dst_top_tb
    import dst_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, word_taken, serial_out, serial_out_n;
    logic emph_out, emph_active, pll_lock, clk200_tick;
    logic load_en = 1'b0;
    logic [29:0] data_in = 30'h0;
    logic [29:0] rx_word;
    logic [7:0] rx_cnt;
    dst_drive_s drive;
    dst_pll_s pll_ctl;
    dst_rate_e rx_rate = DST_RATE_1G2;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    logic [31:0] q;
    logic e;
    always #5 pclk = ~pclk;
    dst_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .load_en, .data_in,
        .word_taken, .serial_out, .serial_out_n, .emph_out,
        .emph_active, .clk200_tick, .pll_lock, .drive, .pll_ctl);
    dst_rx rx_u (.pclk, .presetn, .word_taken, .serial_out,
        .rate(rx_rate), .rx_word, .rx_cnt);
    // ====================================================
    // shared tasks
    task automatic summarize();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_lock();
        repeat (1500) begin
            @(posedge pclk);
            if (pll_lock === 1'b1) break;
        end
        chk(pll_lock, 1);
    endtask
    function automatic logic [29:0] triple(input logic [9:0] b);
        logic [29:0] r;
        for (int i = 0; i < 10; i++) r[3*i +: 3] = {3{b[i]}};
        return r;
    endfunction
    // ====================================================
    // scenarios
    task automatic t_regs();
        apb(1'b0, `DST_PLL_OFS, 32'h0);
        chk(q, 32'h50);
        apb(1'b0, 12'h010, 32'h0);
        chk({q[30:0], e}, 32'h1);
        apb(1'b1, `DST_DRIVE_OFS, 32'hA5);
        repeat (2) @(posedge pclk);
        chk({drive.main_code, drive.emph_code}, 32'h5A);
        apb(1'b1, `DST_STATUS_OFS, 32'hFF);
        apb(1'b0, `DST_STATUS_OFS, 32'h0);
        chk(q[0], 0);
    endtask
    task automatic t_pll();
        logic [1:0] code [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        logic [2:0] stg [4] = '{3'h3, 3'h4, 3'h5, 3'h4};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `DST_PLL_OFS, {24'h0, 4'h9, 1'b0, i[0], code[i]});
            repeat (2) @(posedge pclk);
            chk(pll_ctl.vco_stages, stg[i]);
            chk(pll_ctl.cp_code, 4'h9);
        end
        apb(1'b1, `DST_PLL_OFS, 32'h58);
        repeat (2) @(posedge pclk);
        chk({pll_ctl.power_down, pll_lock}, 2'h2);
        apb(1'b1, `DST_PLL_OFS, 32'h50);
    endtask
    task automatic t_rate(input dst_rate_e r, input logic [29:0] w);
        logic [7:0] n0;
        data_in <= w;
        load_en <= 1'b1;
        apb(1'b1, `DST_CTRL_OFS, {29'h0, r, 1'b0});
        // receiver follows only once the new rate is in force
        rx_rate <= r;
        n0 = rx_cnt;
        repeat (600) begin
            @(posedge pclk);
            if (rx_cnt == n0 + 8'h03) break;
        end
        chk(rx_word, w);
        chk(rx_cnt, n0 + 8'h03);
        if (r != DST_RATE_600) begin
            n0 = 8'h00;
            repeat (60) begin
                @(posedge pclk);
                n0 += 8'(clk200_tick === 1'b1);
            end
            chk(n0, 8'h0A);
        end
    endtask
    task automatic t_disable();
        int n;
        n = 0;
        apb(1'b1, `DST_CTRL_OFS, 32'h1);
        repeat (100) begin
            @(posedge pclk);
            n += int'(word_taken === 1'b1);
        end
        chk(n, 0);
        chk({pll_ctl.power_down, pll_lock}, 2'h2);
        apb(1'b0, `DST_STATUS_OFS, 32'h0);
        chk(q[1:0], 2'h1);
        load_en <= 1'b0;
        apb(1'b1, `DST_CTRL_OFS, 32'h0);
        wait_lock();
    endtask
    // ====================================================
    // main sequence and hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({serial_out, serial_out_n, word_taken}, 3'h2);
        chk(pll_ctl, {1'b1, 3'h3, 4'h5});
        @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_pll();
        wait_lock();
        t_rate(DST_RATE_1G2, 30'h2A5C3F19);
        t_rate(DST_RATE_600, 30'h1F0E1D2C);
        t_rate(DST_RATE_400, triple(10'h2D3));
        t_disable();
        summarize();
    end
endmodule
bind dst_top dst_checker chk_u (.pclk, .presetn, .psel, .penable,
    .paddr, .pslverr, .word_taken, .serial_out, .serial_out_n,
    .emph_out, .emph_active, .pll_lock, .pll_ctl);
